// file: dv/fail_safe_clock_switch_tb_top.sv
`timescale 1ns/1ps
// Bench for the clock selector and fail-safe monitor
module fail_safe_clock_switch_tb_top;
    import fcs_pkg::*;

    typedef struct {logic [2:0] src; logic [2:0] exp;} fcs_row_t;

    logic clk, rst, wake_event, key_wr, other_reg_acc, ctl_wr, ctl_switch_req, ctl_clr_fail;
    logic irq_wr, irq_enable_in, irq_flag_clr, low_power_rc_tick, pri_edge, pll_lock_status;
    logic pri_alive, lock_ok, switch_request, clock_fail_flag, unlocked;
    logic fail_irq_enable, fail_irq_flag, fail_irq_req;
    logic [1:0] switch_monitor_config, primary_submode_config, irq_subpriority_in, fail_irq_subpriority;
    logic [2:0] default_source_config, ctl_new_source, irq_priority_in, current_source, new_source;
    logic [2:0] fail_irq_priority;
    logic [5:0] src_running, src_in_use_other, src_enable, present;
    logic [31:0] key_data;
    int error_cnt, tests_run, cyc;
    // Ordinary switches: secondary, redundant repeat, fast RC, low-power RC, primary
    fcs_row_t rows [5] = '{'{3'h4, 3'h4}, '{3'h4, 3'h4}, '{3'h0, 3'h0}, '{3'h5, 3'h5}, '{3'h2, 3'h2}};

    fcs_top dut (.clk(clk), .rst(rst), .switch_monitor_config(switch_monitor_config),
        .default_source_config(default_source_config), .primary_submode_config(primary_submode_config),
        .wake_event(wake_event), .key_wr(key_wr), .key_data(key_data), .other_reg_acc(other_reg_acc),
        .ctl_wr(ctl_wr), .ctl_new_source(ctl_new_source), .ctl_switch_req(ctl_switch_req),
        .ctl_clr_fail(ctl_clr_fail), .irq_wr(irq_wr), .irq_enable_in(irq_enable_in),
        .irq_flag_clr(irq_flag_clr), .irq_priority_in(irq_priority_in),
        .irq_subpriority_in(irq_subpriority_in), .low_power_rc_tick(low_power_rc_tick), .pri_edge(pri_edge),
        .src_running(src_running), .src_in_use_other(src_in_use_other),
        .pll_lock_status(pll_lock_status), .current_source(current_source), .new_source(new_source),
        .switch_request(switch_request), .clock_fail_flag(clock_fail_flag), .unlocked(unlocked),
        .fail_irq_enable(fail_irq_enable), .fail_irq_flag(fail_irq_flag),
        .fail_irq_priority(fail_irq_priority), .fail_irq_subpriority(fail_irq_subpriority),
        .fail_irq_req(fail_irq_req), .src_enable(src_enable));

    fcs_osc_model osc (.clk(clk), .rst(rst), .pri_alive(pri_alive), .present(present), .lock_ok(lock_ok),
        .src_enable(src_enable), .low_power_rc_tick(low_power_rc_tick), .pri_edge(pri_edge),
        .src_running(src_running), .pll_lock_status(pll_lock_status));

    // 200 MHz clock
    initial
    begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    // Hang guard, well above the longest wait chain
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 30000)
        begin
            error_cnt++;
            end_sim();
        end
    end

    task automatic end_sim();
        $display("Checks run %0d, mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        tests_run++;
        if (g !== e)
        begin
            error_cnt++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask

    // Reset held two cycles; configuration words change only under reset
    task automatic do_reset(input logic [1:0] cfg, input logic [2:0] dflt);
        rst <= 1'b1;
        switch_monitor_config <= cfg;
        default_source_config <= dflt;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
    endtask

    task automatic key(input logic [31:0] d);
        @(posedge clk);
        key_wr <= 1'b1;
        key_data <= d;
        @(posedge clk);
        key_wr <= 1'b0;
    endtask

    task automatic ctl(input logic [2:0] src);
        @(posedge clk);
        ctl_wr <= 1'b1;
        ctl_new_source <= src;
        @(posedge clk);
        ctl_wr <= 1'b0;
        repeat (2) @(posedge clk);
    endtask

    // Polls the request bit the way software would, with a ceiling
    task automatic wait_done();
        int n;
        n = 0;
        while (switch_request !== 1'b0 && n < 400)
        begin
            @(posedge clk);
            n++;
        end
    endtask

    initial
    begin
        {rst, wake_event, key_wr, other_reg_acc, ctl_wr, ctl_clr_fail, irq_wr, irq_flag_clr} = '0;
        {ctl_switch_req, pri_alive, lock_ok} = 3'h7;
        {irq_enable_in, irq_priority_in, irq_subpriority_in} = '0;
        {ctl_new_source, key_data, src_in_use_other, primary_submode_config} = '0;
        // Low-power RC is held by another user throughout
        src_in_use_other = 6'h20;
        switch_monitor_config = 2'h0;
        default_source_config = 3'h0;
        present = 6'h3D;
        error_cnt = 0;
        tests_run = 0;
        cyc = 0;
        do_reset(FCS_CFG_SW_MON, 3'h0);
        chk("reset source", 8'h00, current_source);
        chk("reset enables", 8'h01, src_enable);
        chk("reset flags", 8'h00, {clock_fail_flag, fail_irq_flag, unlocked, switch_request});
        // Interrupt set-up with the enable left off
        @(posedge clk);
        irq_wr <= 1'b1;
        irq_priority_in <= 3'h5;
        irq_subpriority_in <= 2'h2;
        @(posedge clk);
        irq_wr <= 1'b0;
        @(posedge clk);
        chk("priority", 8'h05, fail_irq_priority);
        chk("subpriority", 8'h02, fail_irq_subpriority);
        ctl(3'h4);
        chk("locked write", 8'h00, switch_request);
        key(FCS_KEY1);
        @(posedge clk);
        other_reg_acc <= 1'b1;
        @(posedge clk);
        other_reg_acc <= 1'b0;
        key(FCS_KEY2);
        @(posedge clk);
        chk("split unlock", 8'h00, unlocked);
        key(FCS_KEY1);
        key(FCS_KEY2);
        @(posedge clk);
        chk("unlock", 8'h01, unlocked);
        foreach (rows[i])
        begin
            ctl(rows[i].src);
            wait_done();
            chk("switch done", 8'h00, switch_request);
            chk("switched source", rows[i].exp, current_source);
            chk("still open", 8'h01, unlocked);
        end
        chk("old kept", 8'h24, src_enable);
        // Primary dies while selected with the interrupt masked
        pri_alive <= 1'b0;
        repeat (100) @(posedge clk);
        chk("fail source", 8'h00, current_source);
        chk("fail flags", 8'h03, {clock_fail_flag, fail_irq_flag});
        chk("masked req", 8'h00, fail_irq_req);
        repeat (20) @(posedge clk);
        chk("stay on rc", 8'h00, current_source);
        // Enable after the event: request follows the pending flag until cleared
        @(posedge clk);
        irq_wr <= 1'b1;
        irq_enable_in <= 1'b1;
        @(posedge clk);
        irq_wr <= 1'b0;
        repeat (2) @(posedge clk);
        chk("irq req", 8'h01, fail_irq_req);
        irq_flag_clr <= 1'b1;
        @(posedge clk);
        irq_flag_clr <= 1'b0;
        repeat (2) @(posedge clk);
        chk("irq cleared", 8'h00, {fail_irq_flag, fail_irq_req});
        // Absent source: request must stay pending
        ctl(3'h1);
        repeat (200) @(posedge clk);
        chk("absent src", 8'h01, switch_request);
        key(32'h33333333);
        ctl(3'h4);
        chk("relocked", 8'h01, new_source);
        // PLL to PLL is refused
        do_reset(FCS_CFG_SW_MON, 3'h0);
        pri_alive <= 1'b1;
        key(FCS_KEY1);
        key(FCS_KEY2);
        ctl(3'h3);
        wait_done();
        chk("to pri pll", 8'h03, current_source);
        ctl(3'h1);
        wait_done();
        chk("pll to pll", 8'h03, current_source);
        // Secondary stops before a wake: start delay runs out, fast RC takes over
        ctl(3'h4);
        wait_done();
        chk("to secondary", 8'h04, current_source);
        present <= 6'h2D;
        wake_event <= 1'b1;
        @(posedge clk);
        wake_event <= 1'b0;
        repeat (40) @(posedge clk);
        chk("delay running", 8'h04, current_source);
        repeat (60) @(posedge clk);
        chk("slow start src", 8'h00, current_source);
        chk("slow start flag", 8'h01, clock_fail_flag);
        chk("starter off", 8'h21, src_enable);
        ctl_clr_fail <= 1'b1;
        ctl(3'h0);
        ctl_clr_fail <= 1'b0;
        chk("flag clear", 8'h00, clock_fail_flag);
        // Switching disabled: default source, request pinned low
        do_reset(2'h2, 3'h3);
        @(posedge clk);
        chk("default src", 8'h03, current_source);
        key(FCS_KEY1);
        key(FCS_KEY2);
        ctl(3'h4);
        chk("req pinned", 8'h00, switch_request);
        chk("no switch", 8'h03, current_source);
        end_sim();
    end
endmodule

// file: dv/fcs_osc_model.sv
`timescale 1ns/1ps
// Oscillator sources as seen from the selector
module fcs_osc_model
(
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       rst,
    // Scenario controls
    input  wire logic       pri_alive,
    input  wire logic [5:0] present,
    input  wire logic       lock_ok,
    // Selector side
    input  wire logic [5:0] src_enable,
    output logic            low_power_rc_tick,
    output logic            pri_edge,
    output logic [5:0]      src_running,
    output logic            pll_lock_status
);
    logic [3:0] div_q;

    // Free-running divider for the slow time bases
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            div_q <= 4'h0;
        else
            div_q <= div_q + 4'h1;
    end

    // Low-power RC ticks every fourth cycle and never stops
    assign low_power_rc_tick = (div_q[1:0] == 2'h3);
    // Primary edges only while the crystal is alive and running
    assign pri_edge = pri_alive & (src_running[2] | src_running[3]) & div_q[0];
    // Lock follows a running PLL source; a dead PLL never locks
    assign pll_lock_status = lock_ok & (src_running[1] | src_running[3]);

    // Sources come up slowly, one tick after being enabled
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            src_running <= 6'h00;
        else if (low_power_rc_tick)
            src_running <= src_enable & present;
    end
endmodule

// file: src/fcs_fail_mon.sv
`timescale 1ns/1ps
// Primary edge watchdog on the low-power RC tick
module fcs_fail_mon
    import fcs_pkg::*;
(
    // Clock and reset
    input  wire logic clk,
    input  wire logic rst,
    // Sampled inputs
    input  wire logic low_power_rc_tick,
    input  wire logic pri_edge,
    input  wire logic arm,
    // Result
    output logic      fail_q
);
    logic [3:0] win_q;

    // ------------------------------------------------------------
    // Window count; restarts on every primary edge
    // ------------------------------------------------------------
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            win_q  <= 4'h0;
            fail_q <= 1'b0;
        end
        else
        begin
            fail_q <= 1'b0;
            if (!arm || pri_edge)
                win_q <= 4'h0;
            else if (low_power_rc_tick)
            begin
                if (win_q == 4'(FCS_MON_WINDOW - 1))
                begin
                    win_q  <= 4'h0;
                    fail_q <= 1'b1;
                end
                else
                    win_q <= win_q + 4'h1;
            end
        end
    end

    win_fail_a: assert property (@(posedge clk) disable iff (rst)
        fail_q |-> $past(arm) && !$past(pri_edge)) else $error("fail without window expiry");
endmodule

// file: src/fcs_pkg.sv
package fcs_pkg;

    // ----------------------------------------------------------------
    // Source encodings
    // ----------------------------------------------------------------
    localparam logic [2:0] FCS_SRC_FRC     = 3'h0;
    localparam logic [2:0] FCS_SRC_FRC_PLL = 3'h1;
    localparam logic [2:0] FCS_SRC_PRI     = 3'h2;
    localparam logic [2:0] FCS_SRC_PRI_PLL = 3'h3;
    localparam logic [2:0] FCS_SRC_SEC     = 3'h4;
    localparam logic [2:0] FCS_SRC_LOW_POWER_RC    = 3'h5;

    // ----------------------------------------------------------------
    // Config fields and control bit positions
    // ----------------------------------------------------------------
    localparam logic [1:0] FCS_CFG_SW_ONLY    = 2'h1;
    localparam logic [1:0] FCS_CFG_SW_MON     = 2'h0;
    localparam int         FCS_BIT_SWREQ      = 0;
    localparam int         FCS_BIT_CFAIL      = 3;

    // ----------------------------------------------------------------
    // Keys
    // ----------------------------------------------------------------
    localparam logic [31:0] FCS_KEY1 = 32'hAA996655;
    localparam logic [31:0] FCS_KEY2 = 32'h556699AA;

    // ----------------------------------------------------------------
    // Timing, counted in low-power RC ticks, and reset values
    // ----------------------------------------------------------------
    localparam int         FCS_MON_WINDOW      = 4;
    localparam int         FCS_START_DELAY     = 16;
    localparam int         FCS_OST_TICKS       = 8;
    localparam logic [4:0] FCS_RST_PRIO        = 5'h00;
    // Only the fast RC is enabled out of reset
    localparam logic [5:0] FCS_RST_EN          = 6'h01;

    // Submodes of the primary oscillator
    localparam logic [1:0] FCS_SUB_EC = 2'h0;
    localparam logic [1:0] FCS_SUB_XT = 2'h1;
    localparam logic [1:0] FCS_SUB_HS = 2'h2;

    typedef enum logic [2:0] {
        FCS_IDLE, FCS_CMP, FCS_WAIT, FCS_HAND
    } fcs_state_t;

endpackage

// file: src/fcs_top.sv
`timescale 1ns/1ps
// Clock source selector with fail-safe monitor and switch sequencer
module fcs_top
    import fcs_pkg::*;
(
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       rst,
    // Configuration words, static
    input  wire logic [1:0] switch_monitor_config,
    input  wire logic [2:0] default_source_config,
    input  wire logic [1:0] primary_submode_config,
    // Wake from sleep and start of monitor delay
    input  wire logic       wake_event,
    // Software register writes
    input  wire logic       key_wr,
    input  wire logic [31:0] key_data,
    input  wire logic       other_reg_acc,
    input  wire logic       ctl_wr,
    input  wire logic [2:0] ctl_new_source,
    input  wire logic       ctl_switch_req,
    input  wire logic       ctl_clr_fail,
    input  wire logic       irq_wr,
    input  wire logic       irq_enable_in,
    input  wire logic       irq_flag_clr,
    input  wire logic [2:0] irq_priority_in,
    input  wire logic [1:0] irq_subpriority_in,
    // Oscillator status
    input  wire logic       low_power_rc_tick,
    input  wire logic       pri_edge,
    input  wire logic [5:0] src_running,
    input  wire logic [5:0] src_in_use_other,
    input  wire logic       pll_lock_status,
    // Status and control out
    output logic [2:0]      current_source,
    output logic [2:0]      new_source,
    output logic            switch_request,
    output logic            clock_fail_flag,
    output logic            unlocked,
    output logic            fail_irq_enable,
    output logic            fail_irq_flag,
    output logic [2:0]      fail_irq_priority,
    output logic [1:0]      fail_irq_subpriority,
    output logic            fail_irq_req,
    output logic [5:0]      src_enable
);

    // ------------------------------------------------------------
    // Decodes
    // ------------------------------------------------------------
    function automatic logic is_pll(input logic [2:0] s);
        is_pll = (s == FCS_SRC_FRC_PLL) || (s == FCS_SRC_PRI_PLL);
    endfunction

    function automatic logic is_xtal(input logic [2:0] s, input logic [1:0] sub);
        is_xtal = ((s == FCS_SRC_PRI) || (s == FCS_SRC_PRI_PLL)) && (sub != FCS_SUB_EC)
                  || (s == FCS_SRC_SEC);
    endfunction

    // Switching enabled on 0x, monitor only on 00
    wire sw_en  = !switch_monitor_config[1];
    wire mon_en = (switch_monitor_config == FCS_CFG_SW_MON);
    // Primary is watched whether plain or with PLL
    wire on_pri = (current_source == FCS_SRC_PRI) ||
                  (current_source == FCS_SRC_PRI_PLL);
    wire need_delay = mon_en && is_xtal(current_source, primary_submode_config);

    // ------------------------------------------------------------
    // Unlock key sequence
    // ------------------------------------------------------------
    logic half_q;
    logic unl_d;
    logic half_d;
    always_comb
    begin
        unl_d  = unlocked;
        half_d = half_q;
        if (key_wr)
        begin
            half_d = (key_data == FCS_KEY1);
            unl_d  = half_q && (key_data == FCS_KEY2);
        end
        else if (other_reg_acc)
            half_d = 1'b0;
    end

    // ------------------------------------------------------------
    // Monitor start delay at wake
    // ------------------------------------------------------------
    logic [4:0] dly_q;
    logic       dly_run_q;
    logic       dly_pend_q;
    wire        arm = on_pri && mon_en && !dly_run_q && !dly_pend_q;
    wire        dly_exp = dly_run_q && low_power_rc_tick && (dly_q == 5'(FCS_START_DELAY - 1));
    wire        slow_fail = dly_exp && need_delay && !src_running[current_source];
    logic       mon_fail;

    fcs_fail_mon u_mon (
        .clk       (clk),
        .rst       (rst),
        .low_power_rc_tick (low_power_rc_tick),
        .pri_edge  (pri_edge),
        .arm       (arm),
        .fail_q    (mon_fail)
    );

    wire fail_ev = (mon_fail || slow_fail) && mon_en;

    // Delay starts at wake only; at reset release (pend) the fast RC is selected, so none starts
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            dly_pend_q <= 1'b1;
            dly_run_q  <= 1'b0;
            dly_q      <= 5'h00;
        end
        else
        begin
            dly_pend_q <= 1'b0;
            if ((dly_pend_q || wake_event) && need_delay)
            begin
                dly_run_q <= 1'b1;
                dly_q     <= 5'h00;
            end
            else if (dly_run_q && low_power_rc_tick)
            begin
                dly_q <= dly_q + 5'h01;
                if (dly_exp)
                    dly_run_q <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // Switch sequencer, runs beside the core without stall
    // ------------------------------------------------------------
    fcs_state_t st_q;
    logic [3:0] ost_q;
    wire        target_run = src_running[new_source];
    wire        ready = is_pll(new_source) ? (pll_lock_status && target_run)
                      : is_xtal(new_source, primary_submode_config) ? (ost_q == 4'(FCS_OST_TICKS))
                      : target_run;
    wire        pll_pll = is_pll(new_source) && is_pll(current_source);

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            st_q <= FCS_IDLE;
            ost_q <= 4'h0;
        end
        else if (fail_ev || !sw_en)
            st_q <= FCS_IDLE;
        else
        begin
            case (st_q)
                FCS_IDLE:
                    if (switch_request)
                        st_q <= FCS_CMP;
                FCS_CMP:
                begin
                    ost_q <= 4'h0;
                    if (new_source == current_source || pll_pll)
                        st_q <= FCS_IDLE;
                    else
                        st_q <= FCS_WAIT;
                end
                FCS_WAIT:
                begin
                    // Holds here until a fail event if the source never comes up
                    if (target_run && low_power_rc_tick && ost_q != 4'(FCS_OST_TICKS))
                        ost_q <= ost_q + 4'h1;
                    if (ready)
                        st_q <= FCS_HAND;
                end
                FCS_HAND:
                    st_q <= FCS_IDLE;
                default:
                    st_q <= FCS_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Control and status registers
    // ------------------------------------------------------------
    wire ctl_ok = ctl_wr && unlocked;

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            current_source  <= FCS_SRC_FRC;
            new_source      <= FCS_SRC_FRC;
            switch_request  <= 1'b0;
            clock_fail_flag <= 1'b0;
            unlocked        <= 1'b0;
            half_q          <= 1'b0;
        end
        else
        begin
            unlocked  <= unl_d;
            half_q    <= half_d;
            if (!sw_en)
            begin
                current_source <= default_source_config;
                switch_request <= 1'b0;
            end
            else if (fail_ev)
            begin
                current_source <= FCS_SRC_FRC;
                switch_request <= 1'b0;
            end
            else
            begin
                if (ctl_ok)
                begin
                    new_source <= ctl_new_source;
                    if (ctl_switch_req)
                        switch_request <= 1'b1;
                end
                if (st_q == FCS_CMP && (new_source == current_source || pll_pll))
                    switch_request <= 1'b0;
                if (st_q == FCS_HAND)
                begin
                    current_source <= new_source;
                    switch_request <= 1'b0;
                end
            end
            // Set wins over a software clear in the same cycle
            if (fail_ev)
                clock_fail_flag <= 1'b1;
            else if (ctl_ok && ctl_clr_fail)
                clock_fail_flag <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Interrupt flag, enable and priority
    // ------------------------------------------------------------
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            fail_irq_enable      <= 1'b0;
            fail_irq_flag        <= 1'b0;
            fail_irq_priority    <= FCS_RST_PRIO[4:2];
            fail_irq_subpriority <= FCS_RST_PRIO[1:0];
            fail_irq_req         <= 1'b0;
        end
        else
        begin
            if (irq_wr)
            begin
                fail_irq_enable      <= irq_enable_in;
                fail_irq_priority    <= irq_priority_in;
                fail_irq_subpriority <= irq_subpriority_in;
            end
            if (fail_ev)
                fail_irq_flag <= 1'b1;
            else if (irq_flag_clr)
                fail_irq_flag <= 1'b0;
            fail_irq_req <= (fail_irq_flag || fail_ev) && fail_irq_enable;
        end
    end

    // ------------------------------------------------------------
    // Oscillator enables; old source kept while others use it
    // ------------------------------------------------------------
    wire [5:0] src_en_d;
    genvar gi;
    generate
        for (gi = 0; gi < 6; gi++)
        begin : g_en
            // Target stays on through handover, so it never drops for a cycle
            assign src_en_d[gi] = (current_source == 3'(gi)) || src_in_use_other[gi]
                               || ((st_q == FCS_WAIT || st_q == FCS_HAND) && new_source == 3'(gi) && !fail_ev);
        end
    endgenerate

    // One register for all enables
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            src_enable <= FCS_RST_EN;
        else
            src_enable <= src_en_d;
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    fail_to_frc_a: assert property (@(posedge clk) disable iff (rst)
        fail_ev && sw_en |=> current_source == FCS_SRC_FRC && !switch_request && clock_fail_flag)
        else $error("fail did not move to fast RC");
    fail_flag_a: assert property (@(posedge clk) disable iff (rst)
        fail_ev |=> fail_irq_flag) else $error("irq flag not set");
    irq_gate_a: assert property (@(posedge clk) disable iff (rst)
        fail_irq_req |-> $past(fail_irq_enable)) else $error("irq without enable");
    sw_off_a: assert property (@(posedge clk) disable iff (rst)
        !sw_en && $past(!sw_en) |-> !switch_request) else $error("request set while disabled");
    redundant_a: assert property (@(posedge clk) disable iff (rst)
        st_q == FCS_CMP && new_source == current_source && sw_en && !fail_ev |=> !switch_request)
        else $error("redundant switch not aborted");
    pll_pll_a: assert property (@(posedge clk) disable iff (rst)
        st_q == FCS_CMP && pll_pll |=> st_q == FCS_IDLE) else $error("pll to pll allowed");
    hand_copy_a: assert property (@(posedge clk) disable iff (rst)
        st_q == FCS_HAND && sw_en && !fail_ev |=> current_source == $past(new_source) && !switch_request)
        else $error("handover wrong");
    lock_wait_a: assert property (@(posedge clk) disable iff (rst)
        st_q == FCS_WAIT && is_pll(new_source) && !pll_lock_status |=> st_q != FCS_HAND)
        else $error("handover before lock");
    unlock_a: assert property (@(posedge clk) disable iff (rst)
        $rose(unlocked) |-> $past(key_wr) && $past(key_data) == FCS_KEY2 && $past(half_q))
        else $error("unlock without key pair");
    no_relock_a: assert property (@(posedge clk) disable iff (rst)
        $fell(unlocked) |-> $past(key_wr)) else $error("relock without key write");
endmodule
